// ==== rtl/cms_regs.svh ====
// Behaviour
// - Separate fine shift enables, default off
// - Wait-for-lock pauses startup until lock
// - Chain counter six into counter four
// - Delay compensation on in negative hold and external modes only
// - Spread profile applied when enabled, default center_spread_high
// - Modulation period 4000 to 40000 ns, default 10000
// - Fractions rounded to nearest eighth; out zero with fine shift drops its fraction
// - Shift done pulses one cycle per step
`ifndef CMS_REGS_SVH
`define CMS_REGS_SVH
// Clock period of core_clk in ns
`define CMS_CLK_PERIOD_NS   10
// Reference period limits in ps
`define CMS_REF_PERIOD_MIN  17'h003AA
`define CMS_REF_PERIOD_MAX  17'h186A0
// Spread modulation period limits and default in ns
`define CMS_SS_PERIOD_MIN   16'h0FA0
`define CMS_SS_PERIOD_MAX   16'h9C40
`define CMS_SS_PERIOD_DEF   16'h2710
// Duration of one fine shift step in ns and cycles
`define CMS_SHIFT_STEP_NS   120
`define CMS_SHIFT_STEP_CYC  ((`CMS_SHIFT_STEP_NS + `CMS_CLK_PERIOD_NS - 1) / `CMS_CLK_PERIOD_NS)
// Fixed point layout of a divide or multiply setting
`define CMS_FRAC_BITS       10
`define CMS_FRAC_HALF_EIGHT 11'h040
// Counter limits
`define CMS_DIV_MAX         8'h80
`define CMS_DIV_MIN         8'h01
`endif

// ==== rtl/cms_pkg.sv ====
package cms_pkg;
  // Feedback compensation modes
  typedef enum logic [1:0] {
    CMS_COMP_NEG_HOLD = 2'h0,
    CMS_COMP_EXTERNAL = 2'h1,
    CMS_COMP_INTERNAL = 2'h2,
    CMS_COMP_BUF_IN   = 2'h3
  } cms_comp_t;
  // Spread profile: bit1 center, bit0 high deviation
  typedef enum logic [1:0] {
    CMS_SS_DOWN_LOW    = 2'h0,
    CMS_SS_DOWN_HIGH   = 2'h1,
    CMS_SS_CENTER_SPREAD_LOW  = 2'h2,
    CMS_SS_CENTER_SPREAD_HIGH = 2'h3
  } cms_spread_t;
  // Startup sequence states
  typedef enum logic [2:0] {
    CMS_ST_IDLE = 3'h1,
    CMS_ST_WAIT = 3'h2,
    CMS_ST_DONE = 3'h4
  } cms_start_t;
  // Fine shift states
  typedef enum logic [2:0] {
    CMS_SH_IDLE = 3'h1,
    CMS_SH_BUSY = 3'h2,
    CMS_SH_DONE = 3'h4
  } cms_shift_t;
endpackage

// ==== rtl/cms_div_if.sv ====
`timescale 1ns/10ps
`default_nettype none
// Carries one output counter's tick and divide value
interface cms_div_if;
  logic       tick_in;   // Input tick to count
  logic [7:0] divide;    // Divide value 1 to 128
  logic       tick_out;  // One cycle output tick
  modport ctrl (output tick_in, output divide, input tick_out);
  modport cnt  (input tick_in, input divide, output tick_out);
endinterface
`default_nettype wire

// ==== rtl/cms_divider.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cms_regs.svh"
// One output counter: divides its input ticks
module cms_divider (
  input  wire logic core_clk,
  input  wire logic rst_b,
  cms_div_if.cnt    div
);
  logic [7:0] count_reg;   // Ticks counted so far
  logic [7:0] count_next;
  logic       tick_reg;    // Registered output tick
  logic       tick_next;

  ////////////////////////////////////////////////////////////////
  // Next count and tick
  always_comb begin
    count_next = count_reg;
    tick_next  = 1'b0;
    if (div.tick_in) begin
      // Wrap at divide, zero treated as one
      if (count_reg >= div.divide || div.divide == 8'h00) begin
        count_next = `CMS_DIV_MIN;
        tick_next  = 1'b1;
      end else begin
        count_next = count_reg + 8'h01;
      end
    end
  end

  // Register count and tick
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      count_reg <= `CMS_DIV_MIN;
      tick_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg  <= tick_next;
    end
  end

  assign div.tick_out = tick_reg;

  // Count never passes the largest divide
  count_range_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    count_reg <= `CMS_DIV_MAX) else $error("divider count out of range");
endmodule
`default_nettype wire

// ==== rtl/cms_clock_manager.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cms_regs.svh"
// Static configuration logic of the mixed clock manager
module cms_clock_manager (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Reference periods in ps
  input  wire logic [16:0] primary_ref_period,
  input  wire logic [16:0] secondary_ref_period,
  output logic             ref_period_ok,
  // Fine shift: bit0 feedback, bit1 out zero, bits 7:2 out one to six
  input  wire logic        feedback_fine_shift_en,
  input  wire logic        out_zero_fine_shift_en,
  input  wire logic [5:0]  out_n_fine_shift_en,
  input  wire logic        shift_req,
  input  wire logic [2:0]  shift_sel,
  input  wire logic        shift_inc,
  output logic             shift_busy,
  output logic             shift_done_pulse,
  output logic [9:0]       shift_phase,
  // Divide and multiply settings, 8.10 fixed point
  input  wire logic [17:0] out_zero_divide,
  input  wire logic [17:0] feedback_mult,
  output logic [10:0]      out_zero_divide_q,
  output logic [10:0]      feedback_mult_q,
  output logic             frac_violation,
  // Startup wait
  input  wire logic        startup_wait_en,
  input  wire logic        cfg_start,
  input  wire logic        lock_pin,
  output logic             startup_done,
  // Cascade of counters six and four
  input  wire logic        out_four_chain_enable,
  input  wire logic [7:0]  out_six_divide,
  input  wire logic [7:0]  out_four_divide,
  output logic             output_counter_six,
  output logic             output_counter_four,
  // Compensation
  input  wire logic [1:0]  comp_mode,
  output logic             neg_hold_comp,
  output logic             comp_external,
  output logic             comp_delay_en,
  output logic             comp_manual,
  // Spread spectrum
  input  wire logic        spread_en,
  input  wire logic [1:0]  spread_profile,
  input  wire logic [15:0] spread_mod_period,
  output logic             spread_active,
  output logic             spread_center,
  output logic             spread_dev_high,
  output logic             spread_rising
);

  ////////////////////////////////////////////////////////////////
  // Reference period check
  logic ok_reg;   // Both periods in range
  logic ok_next;
  always_comb begin
    ok_next = (primary_ref_period >= `CMS_REF_PERIOD_MIN) && (primary_ref_period <= `CMS_REF_PERIOD_MAX)
           && (secondary_ref_period >= `CMS_REF_PERIOD_MIN) && (secondary_ref_period <= `CMS_REF_PERIOD_MAX);
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) ok_reg <= 1'b0;
    else ok_reg <= ok_next;
  end
  assign ref_period_ok = ok_reg;

  ////////////////////////////////////////////////////////////////
  // Fractional rounding to eighths
  function automatic logic [10:0] cms_round(input logic [17:0] raw);
    logic [10:0] frac_sum;
    logic [7:0]  int_part;
    frac_sum = {1'b0, raw[9:0]} + `CMS_FRAC_HALF_EIGHT;
    int_part = raw[17:10] + {7'h00, frac_sum[10]};
    return {int_part, frac_sum[9:7]};
  endfunction

  logic [10:0] div0_reg;   // Rounded out zero divide
  logic [10:0] div0_next;
  logic [10:0] mult_reg;   // Rounded feedback multiply
  logic [10:0] mult_next;
  logic        frac_reg;   // Fraction asked with fine shift
  logic        frac_next;
  always_comb begin
    mult_next = cms_round(feedback_mult);
    div0_next = cms_round(out_zero_divide);
    frac_next = 1'b0;
    // Fine shift on out zero keeps integer divide
    if (out_zero_fine_shift_en) begin
      frac_next = (div0_next[2:0] != 3'h0);
      div0_next = {out_zero_divide[17:10], 3'h0};
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      div0_reg <= {`CMS_DIV_MIN, 3'h0};
      mult_reg <= {`CMS_DIV_MIN, 3'h0};
      frac_reg <= 1'b0;
    end else begin
      div0_reg <= div0_next;
      mult_reg <= mult_next;
      frac_reg <= frac_next;
    end
  end
  assign out_zero_divide_q = div0_reg;
  assign feedback_mult_q   = mult_reg;
  assign frac_violation    = frac_reg;

  ////////////////////////////////////////////////////////////////
  // Fine phase shift
  logic [7:0]          shift_en_vec;  // Per target enables
  cms_pkg::cms_shift_t sh_state_reg;  // Shift state
  cms_pkg::cms_shift_t sh_state_next;
  logic [3:0]          sh_cnt_reg;    // Step cycles left
  logic [3:0]          sh_cnt_next;
  logic [2:0]          sh_sel_reg;    // Target being shifted
  logic [2:0]          sh_sel_next;
  logic                sh_inc_reg;    // Step direction
  logic                sh_inc_next;
  logic [9:0]          phase_q [8];   // Phase per target
  logic [9:0]          ph_out_reg;    // Phase of last target
  assign shift_en_vec = {out_n_fine_shift_en, out_zero_fine_shift_en, feedback_fine_shift_en};

  // Shift sequence
  always_comb begin
    sh_state_next = sh_state_reg;
    sh_cnt_next   = sh_cnt_reg;
    sh_sel_next   = sh_sel_reg;
    sh_inc_next   = sh_inc_reg;
    case (sh_state_reg)
      cms_pkg::CMS_SH_IDLE: begin
        // Disabled targets ignore requests
        if (shift_req && shift_en_vec[shift_sel]) begin
          sh_state_next = cms_pkg::CMS_SH_BUSY;
          sh_cnt_next   = 4'(`CMS_SHIFT_STEP_CYC - 1);
          sh_sel_next   = shift_sel;
          sh_inc_next   = shift_inc;
        end
      end
      cms_pkg::CMS_SH_BUSY: begin
        if (sh_cnt_reg == 4'h0) sh_state_next = cms_pkg::CMS_SH_DONE;
        else sh_cnt_next = sh_cnt_reg - 4'h1;
      end
      cms_pkg::CMS_SH_DONE: sh_state_next = cms_pkg::CMS_SH_IDLE;
      default: sh_state_next = cms_pkg::CMS_SH_IDLE;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sh_state_reg <= cms_pkg::CMS_SH_IDLE;
      sh_cnt_reg   <= 4'h0;
      sh_sel_reg   <= 3'h0;
      sh_inc_reg   <= 1'b0;
    end else begin
      sh_state_reg <= sh_state_next;
      sh_cnt_reg   <= sh_cnt_next;
      sh_sel_reg   <= sh_sel_next;
      sh_inc_reg   <= sh_inc_next;
    end
  end

  // Phase step counter per target
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_phase
      logic [9:0] ph_reg;
      logic [9:0] ph_next;
      always_comb begin
        ph_next = ph_reg;
        if (sh_state_reg == cms_pkg::CMS_SH_DONE && sh_sel_reg == 3'(gi))
          ph_next = sh_inc_reg ? ph_reg + 10'h001 : ph_reg - 10'h001;
      end
      always_ff @(posedge core_clk) begin
        if (!rst_b) ph_reg <= 10'h000;
        else ph_reg <= ph_next;
      end
      assign phase_q[gi] = ph_reg;
    end
  endgenerate
  always_ff @(posedge core_clk) begin
    if (!rst_b) ph_out_reg <= 10'h000;
    else ph_out_reg <= phase_q[sh_sel_reg];
  end
  assign shift_phase      = ph_out_reg;
  assign shift_busy       = (sh_state_reg != cms_pkg::CMS_SH_IDLE);
  assign shift_done_pulse = (sh_state_reg == cms_pkg::CMS_SH_DONE);

  ////////////////////////////////////////////////////////////////
  // Lock synchroniser and startup
  logic                lock_m1_reg;  // First stage
  logic                lock_m2_reg;  // Second stage
  logic                lock_m3_reg;  // Third stage
  logic                lock_reg;     // Filtered lock
  logic                lock_next;
  cms_pkg::cms_start_t st_reg;       // Startup state
  cms_pkg::cms_start_t st_next;
  always_comb begin
    lock_next = (lock_m2_reg == lock_m3_reg) ? lock_m3_reg : lock_reg;
    st_next   = st_reg;
    case (st_reg)
      cms_pkg::CMS_ST_IDLE: begin
        if (cfg_start) begin
          // Hold off startup when waiting for lock
          if (startup_wait_en && !lock_reg) st_next = cms_pkg::CMS_ST_WAIT;
          else st_next = cms_pkg::CMS_ST_DONE;
        end
      end
      cms_pkg::CMS_ST_WAIT: if (lock_reg) st_next = cms_pkg::CMS_ST_DONE;
      cms_pkg::CMS_ST_DONE: st_next = cms_pkg::CMS_ST_DONE;
      default: st_next = cms_pkg::CMS_ST_IDLE;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      lock_m1_reg <= 1'b0;
      lock_m2_reg <= 1'b0;
      lock_m3_reg <= 1'b0;
      lock_reg    <= 1'b0;
      st_reg      <= cms_pkg::CMS_ST_IDLE;
    end else begin
      lock_m1_reg <= lock_pin;
      lock_m2_reg <= lock_m1_reg;
      lock_m3_reg <= lock_m2_reg;
      lock_reg    <= lock_next;
      st_reg      <= st_next;
    end
  end
  assign startup_done = (st_reg == cms_pkg::CMS_ST_DONE);

  ////////////////////////////////////////////////////////////////
  // Counters six and four with optional chain
  cms_div_if six_if ();
  cms_div_if four_if ();
  assign six_if.tick_in  = 1'b1;
  assign six_if.divide   = out_six_divide;
  assign four_if.tick_in = out_four_chain_enable ? six_if.tick_out : 1'b1;
  assign four_if.divide  = out_four_divide;
  cms_divider u_six  (.core_clk(core_clk), .rst_b(rst_b), .div(six_if));
  cms_divider u_four (.core_clk(core_clk), .rst_b(rst_b), .div(four_if));
  assign output_counter_six  = six_if.tick_out;
  assign output_counter_four = four_if.tick_out;

  ////////////////////////////////////////////////////////////////
  // Compensation mode decode
  cms_pkg::cms_comp_t comp_sel;
  logic [3:0]         comp_reg;   // hold, external, delay, manual
  logic [3:0]         comp_next;
  assign comp_sel = cms_pkg::cms_comp_t'(comp_mode);
  always_comb begin
    case (comp_sel)
      cms_pkg::CMS_COMP_NEG_HOLD: comp_next = 4'hA;
      cms_pkg::CMS_COMP_EXTERNAL: comp_next = 4'h7;
      cms_pkg::CMS_COMP_INTERNAL: comp_next = 4'h1;
      default:                    comp_next = 4'h1;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) comp_reg <= 4'hA;
    else comp_reg <= comp_next;
  end
  assign neg_hold_comp = comp_reg[3];
  assign comp_external = comp_reg[2];
  assign comp_delay_en = comp_reg[1];
  assign comp_manual   = comp_reg[0];

  ////////////////////////////////////////////////////////////////
  // Spread modulation
  logic [15:0] ss_ns;          // Period in use, ns
  logic [12:0] ss_half;        // Half period in cycles
  logic [12:0] ss_cnt_reg;     // Cycles in this half
  logic [12:0] ss_cnt_next;
  logic [3:0]  ss_reg;         // active, center, high deviation, rising
  logic [3:0]  ss_next;
  always_comb begin
    if (spread_mod_period == 16'h0000) ss_ns = `CMS_SS_PERIOD_DEF;
    else if (spread_mod_period < `CMS_SS_PERIOD_MIN) ss_ns = `CMS_SS_PERIOD_MIN;
    else if (spread_mod_period > `CMS_SS_PERIOD_MAX) ss_ns = `CMS_SS_PERIOD_MAX;
    else ss_ns = spread_mod_period;
    ss_half     = 13'(ss_ns / (2 * `CMS_CLK_PERIOD_NS));
    ss_cnt_next = ss_cnt_reg;
    ss_next     = {1'b0, spread_profile, 1'b1};
    if (spread_en) begin
      ss_next[3] = 1'b1;
      // Flip direction at each half period
      if (ss_cnt_reg + 13'h0001 >= ss_half) begin
        ss_cnt_next = 13'h0000;
        ss_next[0]  = ~ss_reg[0];
      end else begin
        ss_cnt_next = ss_cnt_reg + 13'h0001;
        ss_next[0]  = ss_reg[0];
      end
    end else begin
      ss_cnt_next = 13'h0000;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ss_cnt_reg <= 13'h0000;
      ss_reg     <= {1'b0, cms_pkg::CMS_SS_CENTER_SPREAD_HIGH, 1'b1};
    end else begin
      ss_cnt_reg <= ss_cnt_next;
      ss_reg     <= ss_next;
    end
  end
  assign spread_active   = ss_reg[3];
  assign spread_center   = ss_reg[2];
  assign spread_dev_high = ss_reg[1];
  assign spread_rising   = ss_reg[0];

  ////////////////////////////////////////////////////////////////
  // Checks
  done_one_cycle_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    shift_done_pulse |=> !shift_done_pulse) else $error("shift done longer than one cycle");
  step_length_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(shift_busy) |-> ##12 shift_done_pulse) else $error("shift step length wrong");
  disabled_target_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !shift_busy && shift_req && !shift_en_vec[shift_sel] |=> !shift_busy) else $error("disabled shift taken");
  wait_lock_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    startup_done && $changed(startup_done) && startup_wait_en |-> $past(lock_reg)) else $error("startup ended unlocked");
  no_wait_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    st_reg == cms_pkg::CMS_ST_IDLE && cfg_start && !startup_wait_en |=> startup_done) else $error("startup waited");
  chain_tick_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    out_four_chain_enable && $past(out_four_chain_enable) && output_counter_four |-> $past(output_counter_six))
    else $error("chained tick without counter six");
  integer_div_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $past(out_zero_fine_shift_en) |-> out_zero_divide_q[2:0] == 3'h0) else $error("fraction kept with fine shift");
  round_eighth_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    feedback_mult[9:0] == 10'h03F |=> feedback_mult_q[2:0] == 3'h0) else $error("rounding wrong");
  comp_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    comp_mode == 2'h0 |=> neg_hold_comp && comp_delay_en && !comp_manual) else $error("hold mode decode wrong");
  spread_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !spread_en |=> !spread_active && spread_rising) else $error("spread active when off");
  period_ok_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    primary_ref_period == 17'h00000 || secondary_ref_period == 17'h00000 |=> !ref_period_ok)
    else $error("zero period accepted");
endmodule
`default_nettype wire

// ==== verification/clock_manager_static_config_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cms_regs.svh"
// Compare helper: counts every check and reports a mismatch at once
`define CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("ERROR %0t mismatch got %0h exp %0h", $time, (got), (exp)); \
  end \
end
module clock_manager_static_config_tb;
  ////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [16:0] primary_ref_period = 17'h02710;
  logic [16:0] secondary_ref_period = 17'h02710;
  logic        feedback_fine_shift_en = 1'b0;
  logic        out_zero_fine_shift_en = 1'b0;
  logic [5:0]  out_n_fine_shift_en = 6'h00;
  logic        shift_req = 1'b0;
  logic [2:0]  shift_sel = 3'h0;
  logic        shift_inc = 1'b1;
  logic [17:0] out_zero_divide = 18'h00400;
  logic [17:0] feedback_mult = 18'h00400;
  logic        startup_wait_en = 1'b0;
  logic        cfg_start = 1'b0;
  logic        lock_pin = 1'b0;
  logic        out_four_chain_enable = 1'b0;
  logic [7:0]  out_six_divide = 8'h02;
  logic [7:0]  out_four_divide = 8'h03;
  logic [1:0]  comp_mode = 2'h0;
  logic        spread_en = 1'b0;
  logic [1:0]  spread_profile = 2'h3;
  logic [15:0] spread_mod_period = 16'h0000;
  logic        ref_period_ok, shift_busy, shift_done_pulse, frac_violation, startup_done;
  logic [9:0]  shift_phase;
  logic [10:0] out_zero_divide_q, feedback_mult_q;
  logic        output_counter_six, output_counter_four;
  logic        neg_hold_comp, comp_external, comp_delay_en, comp_manual;
  logic        spread_active, spread_center, spread_dev_high, spread_rising;
  int          bad_count = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          n;
  ////////////////////////////////////////////////////////////////////////////
  // Design under test
  cms_clock_manager cms_clock_manager_i (
    .core_clk, .rst_b, .primary_ref_period, .secondary_ref_period, .ref_period_ok,
    .feedback_fine_shift_en, .out_zero_fine_shift_en, .out_n_fine_shift_en, .shift_req,
    .shift_sel, .shift_inc, .shift_busy, .shift_done_pulse, .shift_phase,
    .out_zero_divide, .feedback_mult, .out_zero_divide_q, .feedback_mult_q, .frac_violation,
    .startup_wait_en, .cfg_start, .lock_pin, .startup_done,
    .out_four_chain_enable, .out_six_divide, .out_four_divide, .output_counter_six,
    .output_counter_four, .comp_mode, .neg_hold_comp, .comp_external, .comp_delay_en,
    .comp_manual, .spread_en, .spread_profile, .spread_mod_period, .spread_active,
    .spread_center, .spread_dev_high, .spread_rising
  );
  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 80000) begin
      bad_count++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Access tasks
  // Advance k edges, then settle 1 ns past the edge
  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  // Reset held for six edges
  task automatic do_reset();
    rst_b = 1'b0;
    step(6);
    rst_b = 1'b1;
  endtask
  // One fine shift step, done expected exactly 12 cycles after the taking edge
  task automatic shift(input logic [2:0] sel);
    shift_sel = sel;
    shift_req = 1'b1;
    step(1);
    shift_req = 1'b0;
    `CHK({shift_busy, shift_done_pulse}, 2'b10)
    for (int k = 1; k <= 11; k++) begin
      step(1);
      `CHK({shift_busy, shift_done_pulse}, 2'b10)
    end
    step(1);
    `CHK({shift_busy, shift_done_pulse}, 2'b11)
    step(1);
    `CHK({shift_busy, shift_done_pulse}, 2'b00)
  endtask
  // Event seen: a counter tick, or a change of the modulation direction
  function automatic logic hit(input int w, input logic last);
    if (w == 0) return output_counter_six === 1'b1;
    if (w == 1) return output_counter_four === 1'b1;
    return spread_rising !== last;
  endfunction
  // Cycles between two consecutive events
  task automatic gap(input int w, output int g);
    logic last;
    last = spread_rising;
    g = 0;
    while (!hit(w, last) && g < 20000) begin
      step(1);
      g++;
    end
    last = spread_rising;
    g = 0;
    do begin
      step(1);
      g++;
    end while (!hit(w, last) && g < 20000);
  endtask
  // Counts and verdict
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  logic [16:0] pri [5] = '{17'h003AA, 17'h003A9, 17'h186A0, 17'h186A1, 17'h003AA};
  logic [16:0] sec [5] = '{17'h02710, 17'h02710, 17'h02710, 17'h02710, 17'h00000};
  logic [4:0]  okx = 5'b00101;
  logic [9:0]  frac [4] = '{10'h040, 10'h03F, 10'h0C0, 10'h3C0};
  logic [15:0] per [4] = '{16'h0FA0, 16'h0064, 16'h0000, 16'h9C40};
  int          pgap [4] = '{200, 200, 500, 2000};
  logic [17:0] v;
  initial begin
    step(1);
    do_reset();
    // Values while held in reset, sampled on the last reset edge
    `CHK({ref_period_ok, shift_busy, shift_done_pulse, frac_violation, startup_done}, 5'h00)
    `CHK({out_zero_divide_q, feedback_mult_q, shift_phase}, {11'h008, 11'h008, 10'h000})
    `CHK({neg_hold_comp, comp_external, comp_delay_en, comp_manual}, 4'hA)
    `CHK({spread_active, spread_center, spread_dev_high, spread_rising}, 4'h7)
    // Reference period limits, both inputs
    for (int i = 0; i < 5; i++) begin
      primary_ref_period = pri[i];
      secondary_ref_period = sec[i];
      step(2);
      `CHK(ref_period_ok, okx[i])
    end
    // Shift to disabled targets is ignored
    for (int s = 0; s < 3; s++) begin
      shift_sel = 3'(s);
      shift_req = 1'b1;
      step(1);
      shift_req = 1'b0;
      step(2);
      `CHK(shift_busy, 1'b0)
    end
    // Enabled feedback: two back to back increments, then one decrement
    feedback_fine_shift_en = 1'b1;
    shift(3'h0);
    shift(3'h0);
    step(1);
    `CHK(shift_phase, 10'h002)
    shift_inc = 1'b0;
    shift(3'h0);
    step(1);
    `CHK(shift_phase, 10'h001)
    // Counter six enable is separate
    out_n_fine_shift_en = 6'h20;
    shift_inc = 1'b1;
    shift(3'h7);
    step(1);
    `CHK(shift_phase, 10'h001)
    // Rounding to the nearest eighth, ties upward, carry into integer
    for (int i = 0; i < 4; i++) begin
      v = {8'h05, frac[i]};
      feedback_mult = v;
      out_zero_divide = v;
      step(2);
      `CHK(feedback_mult_q, 11'((v + 18'h00040) >> 7))
      `CHK({out_zero_divide_q, frac_violation}, {11'((v + 18'h00040) >> 7), 1'b0})
    end
    // Fine shift on output zero: integer only, violation flagged
    out_zero_fine_shift_en = 1'b1;
    out_zero_divide = {8'h05, 10'h100};
    step(2);
    `CHK({out_zero_divide_q, frac_violation}, {11'h028, 1'b1})
    // Startup waits for lock
    do_reset();
    startup_wait_en = 1'b1;
    cfg_start = 1'b1;
    step(1);
    cfg_start = 1'b0;
    step(10);
    `CHK(startup_done, 1'b0)
    lock_pin = 1'b1;
    n = 0;
    while (startup_done !== 1'b1 && n < 8) begin
      step(1);
      n++;
    end
    `CHK(startup_done, 1'b1)
    // Without wait, done right after start even with lock low
    lock_pin = 1'b0;
    do_reset();
    startup_wait_en = 1'b0;
    cfg_start = 1'b1;
    step(1);
    cfg_start = 1'b0;
    step(1);
    `CHK(startup_done, 1'b1)
    // Counters alone, chained, and the largest chained ratio
    gap(0, n);
    `CHK(n, 2)
    gap(1, n);
    `CHK(n, 3)
    out_four_chain_enable = 1'b1;
    gap(1, n);
    `CHK(n, 6)
    out_six_divide = 8'h80;
    out_four_divide = 8'h80;
    gap(1, n);
    `CHK(n, 16384)
    // Every compensation mode
    for (int m = 0; m < 4; m++) begin
      comp_mode = 2'(m);
      step(2);
      `CHK({neg_hold_comp, comp_external, comp_delay_en, comp_manual}, {m == 0, m == 1, m < 2, m != 0})
    end
    comp_mode = 2'h0;
    // Every spread profile while enabled
    spread_en = 1'b1;
    for (int p = 0; p < 4; p++) begin
      spread_profile = 2'(p);
      step(2);
      `CHK({spread_active, spread_center, spread_dev_high}, {1'b1, 2'(p)})
    end
    // Modulation period: limits, clamp, default
    for (int i = 0; i < 4; i++) begin
      spread_mod_period = per[i];
      gap(2, n);
      `CHK(n, pgap[i])
    end
    spread_en = 1'b0;
    step(2);
    `CHK({spread_active, spread_rising}, 2'b01)
    conclude();
  end
endmodule
`default_nettype wire
